// >>> common/rst_seq_pkg.sv
// Purpose: Constants for the reset, option byte and flash security sequencer.
// Assumes: One 40 MHz core clock, synchronous active-high reset srst.
// Notes: Overview list below summarises the sequencer.
// Overview of operation
// - Option bit2 one disables watchdog, pin is I/O
// - Option bit1 one refuses halt mode entry
// - Option bit0 selects flash or boot ROM start
// - Secured external flash reads return FF
// - Secured: block writes, option writes, page erase
// - Option byte at 7FFF, readable through FFFF
// - Mass erase allowed even when secured, blocked only in reset; clears security
// - Reset pin or brownout starts initialisation, ends halt
// - Ports float in reset, port D high
// - Idle timer control cleared, oscillator bit set
// - Stack pointer loads 06F, PC and core control registers cleared
// - Serial cleared, tx empty set, timing preset
// - Watchdog held in reset, leaves armed max window
// - Slow clock drives watchdog pin low 16-32 clocks
// - Brownout presets countdown, underflow releases reset
// - Later brownout re-asserts reset and restarts countdown
// - Deep dip adds about 3 ms delay
// - Shallow dip starts countdown at once
// - Brownout disabled: no internal reset, pin only
package rst_seq_pkg;
  localparam logic [14:0] OPTION_ADDR = 15'h7FFF;
  localparam logic [15:0] OPTION_ALIAS = 16'hFFFF;
  localparam int OPT_BOOT_BIT = 0;
  localparam int OPT_HALT_BIT = 1;
  localparam int OPT_WDOG_BIT = 2;
  localparam int OPT_SEC_BIT = 5;
  localparam logic [7:0] SECURED_READ = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] SP_RESET = 8'h6F;
  localparam logic [7:0] IDLE_CTRL_RESET = 8'h40;
  localparam logic [7:0] TX_BUFFER_EMPTY_RESET = 8'h02;
  localparam logic [7:0] FLASH_TIMING_10MHZ = 8'h7A;
  localparam logic [7:0] WDOG_CTRL_RESET = 8'hC1;
  localparam logic [7:0] PORT_D_RESET = 8'hFF;
  localparam logic [11:0] IDLE_PRESET = 12'h0FF;
  localparam int IDLE_DIV = 1;
  localparam int CLKMON_LOW = 16;
  localparam logic [5:0] CLKMON_CNT_MAX = 6'd16;
  localparam int CLK_HZ = 40000000;
  localparam int DEEP_DELAY_US = 3000;
  localparam int DEEP_DELAY_CYC = (CLK_HZ / 1000000) * DEEP_DELAY_US;
  localparam int PAGE_BITS = 7;
  typedef enum logic [2:0] {FOP_NONE, FOP_READ, FOP_WRITE, FOP_PAGE_ERASE,
    FOP_MASS_ERASE} flash_op_t;
  typedef enum {BOR_OFF, BOR_DEEP, BOR_WAIT, BOR_COUNT, BOR_RUN} bor_state_t;
endpackage

// >>> design/reset_option_security_sequencer.sv
// Purpose: Reset sequencing, option byte decode and flash protection.
// Assumes: Supply comparators arrive as synchronous levels.
// Notes: Control registers are presented as reset values on outputs.
module reset_option_security_sequencer (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Board reset pin and supply detectors
  input wire logic resetPinN,
  input wire logic borEnable,
  input wire logic supplyAboveBor,
  input wire logic supplyAboveLow,
  input wire logic clockFreqOk,
  // Core requests
  input wire logic haltRequest,
  input wire logic userIspActive,
  // External flash programming port
  input wire rst_seq_pkg::flash_op_t progOp,
  input wire logic [15:0] progAddr,
  input wire logic [7:0] progWrData,
  output logic [7:0] progRdData,
  output logic progRdValid,
  output logic progRefused,
  // Flash array access
  output logic flashWrEn,
  output logic flashPageErase,
  output logic flashMassErase,
  output logic [14:0] flashAddr,
  output logic [7:0] flashWrData,
  input wire logic [7:0] flashRdData,
  input wire logic [7:0] boot_option_byte,
  // Core status
  output logic coreResetActive,
  output logic haltActive,
  output logic bootFromFlash,
  output logic watchdogEnabled,
  output logic watchdogArmed,
  output logic [7:0] watchdog_ctrl,
  // Reset values presented to core registers
  output logic [14:0] programCounterInit,
  output logic [7:0] stackPointerInit,
  output logic [7:0] idle_timer_control,
  output logic [7:0] processor_status_word,
  output logic [7:0] main_control_reg,
  output logic [7:0] interrupt_control_reg,
  output logic [7:0] timer_two_control,
  output logic [7:0] timer_three_control,
  output logic [7:0] fast_timer_control,
  output logic [7:0] dataSegmentReg,
  output logic [7:0] serial_port_ctrl_a,
  output logic [7:0] serial_port_ctrl_rx,
  output logic [7:0] serial_port_ctrl_irq,
  output logic [7:0] baud_prescaler_reg,
  output logic [7:0] prog_address_low,
  output logic [7:0] prog_address_high,
  output logic [7:0] flash_timing_reg,
  output logic [7:0] wakeup_enable_reg,
  output logic [7:0] wakeup_edge_reg,
  // Pin controls, output enable low means driving
  output logic [7:0] portDOut,
  output logic portsOeN,
  output logic portDOeN,
  output logic pullUpG0G2,
  output logic watchdog_output_pin,
  output logic watchdogPinOeN,
  output logic watchdogPullUp
);
  import rst_seq_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Reset pin and brownout

  logic pinSynced;
  logic pinReset;
  bor_state_t borState_q;
  logic [21:0] deepCnt_q;
  logic [11:0] idleCnt_q;
  logic borReset;
  logic internalReset;

  // Pin low asserts at once, release is clocked
  sync_pair pinSync (
    .sysClk(sys_clk),
    .clkEn(clkEn),
    .clearNow(~resetPinN),
    .syncOut(pinSynced)
  );
  assign pinReset = ~pinSynced;

  // Brownout sequencer; disabled brownout never asserts reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      borState_q <= BOR_OFF;
      deepCnt_q <= '0;
      idleCnt_q <= IDLE_PRESET;
    end else if (clkEn) begin
      if (!borEnable) begin
        borState_q <= BOR_OFF;
      end else if (!supplyAboveLow) begin
        borState_q <= BOR_DEEP;
        deepCnt_q <= '0;
        idleCnt_q <= IDLE_PRESET;
      end else if (!supplyAboveBor && borState_q != BOR_DEEP) begin
        borState_q <= BOR_WAIT;
        idleCnt_q <= IDLE_PRESET;
      end else begin
        unique case (borState_q)
          BOR_OFF: borState_q <= BOR_DEEP;
          BOR_DEEP: begin
            // Delay runs from the low trigger regardless of threshold
            if (deepCnt_q == 22'(DEEP_DELAY_CYC - 1)) begin
              borState_q <= BOR_WAIT;
            end else begin
              deepCnt_q <= deepCnt_q + 22'd1;
            end
          end
          BOR_WAIT: if (supplyAboveBor) borState_q <= BOR_COUNT;
          BOR_COUNT: begin
            if (idleCnt_q == '0) begin
              borState_q <= BOR_RUN;
            end else begin
              idleCnt_q <= idleCnt_q - 12'd1;
            end
          end
          BOR_RUN: borState_q <= BOR_RUN;
        endcase
      end
    end
  end

  assign borReset = borEnable && (borState_q != BOR_RUN);
  assign internalReset = srst | pinReset | borReset;
  assign coreResetActive = internalReset;

  //////////////////////////////////////////////////////////////////////
  // Option byte decode

  logic secure;
  assign secure = boot_option_byte[OPT_SEC_BIT];
  assign watchdogEnabled = ~boot_option_byte[OPT_WDOG_BIT];
  assign bootFromFlash = boot_option_byte[OPT_BOOT_BIT];

  // Halt entry refused by option; reset pin ends halt
  always_ff @(posedge sys_clk) begin
    if (internalReset) begin
      haltActive <= 1'b0;
    end else if (clkEn && haltRequest && !boot_option_byte[OPT_HALT_BIT]) begin
      haltActive <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Programming port protection

  logic isOption;
  logic allowRead;
  logic allowWrite;
  logic allowPage;
  assign isOption = (progAddr == OPTION_ALIAS) || (progAddr[14:0] == OPTION_ADDR);
  assign allowRead = !secure || isOption || userIspActive;
  assign allowWrite = !secure || userIspActive;
  assign allowPage = !secure || userIspActive;

  // Flash strobes pass through only when permitted
  always_comb begin
    flashAddr = isOption ? OPTION_ADDR : progAddr[14:0];
    flashWrData = progWrData;
    flashWrEn = (progOp == FOP_WRITE) && allowWrite && !internalReset;
    flashPageErase = (progOp == FOP_PAGE_ERASE) && allowPage && !internalReset;
    flashMassErase = (progOp == FOP_MASS_ERASE) && !internalReset;
  end

  // Read data registered; secured locations read as all ones
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      progRdData <= ERASED_BYTE;
      progRdValid <= 1'b0;
      progRefused <= 1'b0;
    end else if (clkEn) begin
      progRdValid <= (progOp == FOP_READ);
      progRefused <= (progOp == FOP_WRITE && !allowWrite) ||
        (progOp == FOP_PAGE_ERASE && !allowPage);
      if (progOp == FOP_READ) begin
        progRdData <= isOption ? boot_option_byte :
          (allowRead ? flashRdData : SECURED_READ);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register reset values

  // Cleared and preset values held while reset stands
  always_ff @(posedge sys_clk) begin
    if (internalReset) begin
      programCounterInit <= PC_RESET;
      processor_status_word <= '0;
      main_control_reg <= '0;
      interrupt_control_reg <= '0;
      timer_two_control <= '0;
      timer_three_control <= '0;
      fast_timer_control <= '0;
      dataSegmentReg <= '0;
      idle_timer_control <= IDLE_CTRL_RESET;
      stackPointerInit <= SP_RESET;
      serial_port_ctrl_a <= TX_BUFFER_EMPTY_RESET;
      serial_port_ctrl_rx <= '0;
      serial_port_ctrl_irq <= '0;
      baud_prescaler_reg <= '0;
      prog_address_low <= '0;
      prog_address_high <= '0;
      flash_timing_reg <= FLASH_TIMING_10MHZ;
      wakeup_enable_reg <= '0;
      wakeup_edge_reg <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pins during reset

  // Ports float in reset; port D drives high; G0 and G2 pulled up
  always_ff @(posedge sys_clk) begin
    if (internalReset) begin
      portsOeN <= 1'b1;
      portDOeN <= 1'b0;
      portDOut <= PORT_D_RESET;
      pullUpG0G2 <= 1'b1;
    end else if (clkEn) begin
      pullUpG0G2 <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Watchdog and clock monitor

  logic [5:0] monCnt_q;
  logic monError_q;

  // Circuits inhibited in reset, armed with full window at exit
  always_ff @(posedge sys_clk) begin
    if (internalReset) begin
      watchdogArmed <= 1'b0;
      watchdog_ctrl <= WDOG_CTRL_RESET;
      monError_q <= 1'b0;
      monCnt_q <= '0;
    end else if (clkEn && watchdogEnabled) begin
      watchdogArmed <= 1'b1;
      // Error lasts until frequency has been good for 17 timer clocks
      if (!clockFreqOk) begin
        monError_q <= 1'b1;
        monCnt_q <= '0;
      end else if (monError_q) begin
        if (monCnt_q == CLKMON_CNT_MAX) begin
          monError_q <= 1'b0;
        end else begin
          monCnt_q <= monCnt_q + 6'd1;
        end
      end
    end
  end

  // Watchdog pin drives low only on error; otherwise weak pull-up holds it while the watchdog is enabled, none when disabled
  assign watchdog_output_pin = 1'b0;
  assign watchdogPinOeN = !(watchdogEnabled && monError_q);
  assign watchdogPullUp = watchdogEnabled;
endmodule

// >>> design/sync_pair.sv
// Purpose: Two-flop synchroniser for the release edge of the reset pin.
// Assumes: Clear comes from the raw pin, set on a clock edge.
// Notes: First flop is read only by the second.
module sync_pair (
  // Clock and controls
  input wire logic sysClk,
  input wire logic clkEn,
  input wire logic clearNow,
  // Synchronised level
  output logic syncOut
);
  logic stage1_q;
  logic stage2_q;

  // Clear acts at once so assertion needs no clock; release takes two edges
  always_ff @(posedge sysClk or posedge clearNow) begin
    if (clearNow) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else if (clkEn) begin
      stage1_q <= 1'b1;
      stage2_q <= stage1_q;
    end
  end
  assign syncOut = stage2_q;
endmodule

// >>> verification/flash_prog_model.sv
// Purpose: Flash array and option byte as seen by the sequencer.
// Assumes: Array answers in the same cycle; option byte is 00 from the factory.
// Notes: Array content is a fixed pattern of the address.
module flash_prog_model (
  // Clock
  input wire logic sys_clk,
  // Array strobes and address
  input wire logic flashWrEn,
  input wire logic flashPageErase,
  input wire logic flashMassErase,
  input wire logic [14:0] flashAddr,
  input wire logic [7:0] flashWrData,
  // Array data and option byte
  output logic [7:0] flashRdData,
  output logic [7:0] boot_option_byte
);
  logic [7:0] optQ = 8'h00;
  // Option byte sits at the top address, so reads there show it
  assign flashRdData = (flashAddr == 15'h7FFF) ? optQ : flashAddr[7:0] ^ flashAddr[14:7];
  assign boot_option_byte = optQ;
  // Erasing the last page or the whole array clears the option, and so security
  always_ff @(posedge sys_clk) begin
    if (flashMassErase || (flashPageErase && flashAddr[14:7] == 8'hFF)) begin
      optQ <= 8'h00;
    end else if (flashWrEn && flashAddr == 15'h7FFF) begin
      optQ <= flashWrData;
    end
  end
endmodule

// >>> verification/reset_option_security_sequencer_bench.sv
// Purpose: Self-checking bench for the reset, option and security sequencer.
// Assumes: Brownout mostly off; its 3 ms start delay outlasts the whole run.
// Notes: Option byte is reprogrammed each round, at random after the first two.
module reset_option_security_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rst_seq_pkg::*;
  logic sys_clk = 1'b0, srst = 1'b1, resetPinN = 1'b1, supplyAboveBor = 1'b1;
  logic borEnable = 1'b0;
  logic supplyAboveLow = 1'b1, clockFreqOk = 1'b0, haltRequest = 1'b0, userIspActive = 1'b0;
  flash_op_t progOp = FOP_NONE;
  logic [15:0] progAddr = 16'h0000;
  logic [7:0] progWrData = 8'h00, progRdData, flashWrData, flashRdData, boot_option_byte;
  logic progRdValid, progRefused, flashWrEn, flashPageErase, flashMassErase, coreResetActive;
  logic haltActive, bootFromFlash, watchdogEnabled, watchdogArmed, portsOeN, portDOeN;
  logic pullUpG0G2, watchdog_output_pin, watchdogPinOeN, watchdogPullUp, sec;
  logic [14:0] flashAddr, programCounterInit, a;
  logic [7:0] watchdog_ctrl, stackPointerInit, idle_timer_control, processor_status_word;
  logic [7:0] main_control_reg, interrupt_control_reg, timer_two_control, timer_three_control;
  logic [7:0] fast_timer_control, dataSegmentReg, serial_port_ctrl_a, serial_port_ctrl_rx;
  logic [7:0] serial_port_ctrl_irq, baud_prescaler_reg, prog_address_low, prog_address_high;
  logic [7:0] flash_timing_reg, wakeup_enable_reg, wakeup_edge_reg, portDOut, opt;
  logic [2:0] stb;
  int fails = 0, compares = 0, seed = 32'h11D9768A, n;
  reset_option_security_sequencer i_dut (.clkEn(1'b1), .*);
  flash_prog_model i_flash (.*);
  always #12.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count; a mismatch is printed at once
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t got %0h exp %0h", $time, seen, exp);
    end
  endtask
  // Expected array content, kept apart from the model's own code
  function automatic logic [7:0] pat(input logic [14:0] ad);
    return ad[7:0] ^ ad[14:7];
  endfunction
  // One programmer request; strobes seen in its cycle, answers one cycle later
  task automatic op(input flash_op_t o, input logic [15:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    progOp <= o;
    progAddr <= ad;
    progWrData <= d;
    @(negedge sys_clk);
    stb = {flashWrEn, flashPageErase, flashMassErase};
    @(posedge sys_clk);
    progOp <= FOP_NONE;
    @(negedge sys_clk);
  endtask
  // Board reset held four cycles, longer than one instruction cycle
  task automatic pulse();
    @(posedge sys_clk);
    resetPinN <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({coreResetActive, haltActive, programCounterInit, stackPointerInit, idle_timer_control},
      {2'b10, PC_RESET, SP_RESET, IDLE_CTRL_RESET});
    chk({serial_port_ctrl_a, baud_prescaler_reg, serial_port_ctrl_rx, serial_port_ctrl_irq,
      prog_address_low, prog_address_high, flash_timing_reg},
      {TX_BUFFER_EMPTY_RESET, 40'h0, FLASH_TIMING_10MHZ});
    chk({processor_status_word, main_control_reg, interrupt_control_reg, timer_two_control,
      timer_three_control, fast_timer_control, dataSegmentReg, wakeup_enable_reg,
      wakeup_edge_reg}, 72'h0);
    chk({portDOut, portsOeN, portDOeN, pullUpG0G2}, {PORT_D_RESET, 3'b101});
    @(posedge sys_clk);
    resetPinN <= 1'b1;
    haltRequest <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock starts slow, so the monitor must flag it after the first reset
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    pulse();
    chk({watchdogArmed, watchdog_ctrl, watchdogPinOeN},
      {1'b1, WDOG_CTRL_RESET, 1'b0});
    @(posedge sys_clk);
    clockFreqOk <= 1'b1;
    n = 0;
    while (watchdogPinOeN !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= CLKMON_LOW && n <= 33, 1'b1);
    // Rounds of option programming; first two are secured corner cases
    for (int i = 0; i < 40; i++) begin
      opt = (i < 2) ? {5'h04, {3{i[0]}}} : 8'($random(seed)) & 8'h27;
      op(FOP_MASS_ERASE, 16'h0000, 8'h00);
      chk(stb, 3'b001);
      // While user ISP is off, last page erase only passes if the mass erase really dropped security
      op(FOP_PAGE_ERASE, 16'h7F80, 8'h00);
      chk(stb, 3'b010);
      op(FOP_WRITE, 16'h7FFF, opt);
      chk(stb, 3'b100);
      pulse();
      n = $random(seed);
      // Corner rounds keep user programming off so protection really applies
      if (i < 2) begin
        n[0] = 1'b0;
      end
      @(posedge sys_clk);
      haltRequest <= 1'b1;
      userIspActive <= n[0];
      supplyAboveBor <= n[1];
      supplyAboveLow <= n[2];
      sec = opt[5] & ~n[0];
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({haltActive, bootFromFlash, watchdogEnabled, watchdogArmed, watchdogPullUp},
        {~opt[1], opt[0], {3{~opt[2]}}});
      chk({watchdogPinOeN, watchdog_output_pin, pullUpG0G2}, 3'b100);
      a = 15'($random(seed)) & 15'h3FFF;
      op(FOP_READ, {1'b0, a}, 8'h00);
      chk({progRdValid, progRdData}, {1'b1, sec ? SECURED_READ : pat(a)});
      op(FOP_READ, OPTION_ALIAS, 8'h00);
      chk(progRdData, opt);
      op(FOP_WRITE, {1'b0, a}, 8'h5A);
      chk({stb, progRefused}, {~sec, 2'b00, sec});
      op(FOP_PAGE_ERASE, {1'b0, a}, 8'h00);
      chk({stb, progRefused}, {1'b0, ~sec, 1'b0, sec});
      chk(coreResetActive, 1'b0);
      pulse();
    end
    // Brownout on with supply low holds reset; the full delay is too long to wait out
    @(posedge sys_clk);
    borEnable <= 1'b1;
    supplyAboveBor <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({coreResetActive, haltActive, stackPointerInit}, {2'b10, SP_RESET});
    @(posedge sys_clk);
    borEnable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(coreResetActive, 1'b0);
    summarize();
  end
  // Cut a hang short well beyond the expected run length
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule

// >>> verification/reset_option_security_sequencer_chk.sv
// Purpose: Port checks for the reset, option and security sequencer.
// Assumes: One clock domain; clkEn held high.
// Notes: Bound below the module.
module reset_option_security_sequencer_chk (
  // Clock, reset and inputs
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic resetPinN,
  input wire logic borEnable,
  input wire logic clockFreqOk,
  input wire logic userIspActive,
  input wire rst_seq_pkg::flash_op_t progOp,
  input wire logic [15:0] progAddr,
  input wire logic [7:0] boot_option_byte,
  // Outputs watched
  input wire logic [7:0] progRdData,
  input wire logic progRdValid,
  input wire logic progRefused,
  input wire logic flashWrEn,
  input wire logic flashPageErase,
  input wire logic flashMassErase,
  input wire logic coreResetActive,
  input wire logic haltActive,
  input wire logic watchdogEnabled,
  input wire logic watchdogPinOeN,
  input wire logic portsOeN,
  input wire logic portDOeN,
  input wire logic [7:0] stackPointerInit,
  input wire logic [7:0] idle_timer_control
);
  import rst_seq_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // Secured outside request while the core runs; user ISP bypasses protection
  sequence s_secReq;
    boot_option_byte[OPT_SEC_BIT] && !userIspActive && !coreResetActive;
  endsequence
  sequence s_refused;
    !flashWrEn && !flashPageErase ##1 progRefused;
  endsequence
  sequence s_syncRelease;
    coreResetActive ##1 coreResetActive ##1 !coreResetActive;
  endsequence
  property p_secRead;
    s_secReq ##0 (progOp == FOP_READ && progAddr[14:0] != OPTION_ADDR)
      |=> progRdValid && progRdData == SECURED_READ;
  endproperty
  a_secRead: assert property (p_secRead) else $error("secured read leaked");
  property p_secBlock;
    s_secReq ##0 (progOp inside {FOP_WRITE, FOP_PAGE_ERASE}) |-> s_refused;
  endproperty
  a_secBlock: assert property (p_secBlock) else $error("secured change passed");
  property p_optRead;
    progOp == FOP_READ && progAddr == OPTION_ALIAS && !coreResetActive
      |=> progRdData == $past(boot_option_byte);
  endproperty
  a_optRead: assert property (p_optRead) else $error("option read wrong");
  property p_massErase;
    progOp == FOP_MASS_ERASE && !coreResetActive |-> flashMassErase;
  endproperty
  a_massErase: assert property (p_massErase) else $error("mass erase lost");
  property p_wdogOff;
    !watchdogEnabled |-> watchdogPinOeN;
  endproperty
  a_wdogOff: assert property (p_wdogOff) else $error("disabled watchdog drives");
  property p_haltBlock;
    boot_option_byte[OPT_HALT_BIT] && $past(boot_option_byte[OPT_HALT_BIT]) && !haltActive
      |=> !haltActive;
  endproperty
  a_haltBlock: assert property (p_haltBlock) else $error("halt entered");
  property p_pinAssert;
    !resetPinN |-> coreResetActive ##1 !haltActive;
  endproperty
  a_pinAssert: assert property (p_pinAssert) else $error("pin reset missed");
  property p_release;
    $rose(resetPinN) && !borEnable |-> s_syncRelease;
  endproperty
  a_release: assert property (p_release) else $error("release timing off");
  property p_resetState;
    coreResetActive ##1 coreResetActive |-> portsOeN && !portDOeN
      && stackPointerInit == SP_RESET && idle_timer_control == IDLE_CTRL_RESET;
  endproperty
  a_resetState: assert property (p_resetState) else $error("reset state off");
  property p_clkMon;
    $fell(coreResetActive) && watchdogEnabled && !clockFreqOk |-> ##[0:2] !watchdogPinOeN;
  endproperty
  a_clkMon: assert property (p_clkMon) else $error("clock error not shown");
endmodule
bind reset_option_security_sequencer reset_option_security_sequencer_chk i_chk (.sys_clk,
  .srst, .resetPinN, .borEnable, .clockFreqOk, .userIspActive, .progOp, .progAddr,
  .boot_option_byte, .progRdData, .progRdValid, .progRefused, .flashWrEn, .flashPageErase,
  .flashMassErase, .coreResetActive, .haltActive, .watchdogEnabled, .watchdogPinOeN,
  .portsOeN, .portDOeN, .stackPointerInit, .idle_timer_control);
